// ===== inc/flash_power_pkg.sv
// Constants and types for the flash power-mode and reset controller
package flash_power_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int CNT_W = 32;

   // Reset pulse width, minimum
   localparam int RESET_PULSE_NS = 200;
   localparam int RESET_PULSE_CYC =
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Reset hold period, minimum
   localparam int RESET_HOLD_US = 35;
   localparam int RESET_HOLD_CYC =
      (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Power-up delay, default of our own
   localparam int POWER_UP_DELAY_US = 300;
   localparam int POWER_UP_DELAY_CYC =
      (POWER_UP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Release delay out of deep sleep, default of our own
   localparam int RELEASE_DELAY_NS = 3000;
   localparam int RELEASE_DELAY_CYC =
      (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Chip select deselect time before the pin acts as reset
   localparam int DESELECT_NS = 50;
   localparam int DESELECT_CYC =
      (DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Opcodes and register bits
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
   localparam logic [7:0] OP_DEEP_SLEEP_RELEASE = 8'hab;
   localparam int STATUS_PENDING_BIT = 0;
   localparam int CONFIG_QUAD_BIT = 1;

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_POWER_ON = 3'b000,
      ST_POR_HOLD = 3'b001,
      ST_RUN = 3'b010,
      ST_DEEP_SLEEP = 3'b011,
      ST_RELEASING = 3'b100,
      ST_HW_RESET = 3'b101
   } pwr_state_t;

endpackage

// ===== src/flash_power_mode_reset_ctrl.sv
// Power mode, deep sleep and reset qualification for a serial flash
// Notes on behaviour
// RULE_01: Chip select low means active power.
// RULE_02: Stay active until pending operations finish.
// RULE_03: Opcode b9 enters deep sleep.
// RULE_04: Deep sleep accepted only when nothing pending.
// RULE_05: In deep sleep only ab, then release delay.
// RULE_06: Power-on reset runs for the power-up delay.
// RULE_07: Host keeps chip select high during power-up.
// RULE_08: Pin is reset when deselected long or quad off.
// RULE_09: Reset pin ignored during power-on reset.
// RULE_10: Host waits hold time after late reset.
// RULE_11: Host keeps reset high setup time first.
// RULE_12: Long reset pulse aborts, floats, ignores for hold.
// RULE_13: After release, decode all instructions again.
`timescale 1ns/10ps
`default_nettype none

module flash_power_mode_reset_ctrl #(
   parameter int POWER_UP_CYCLES = flash_power_pkg::POWER_UP_DELAY_CYC,
   parameter int RESET_HOLD_CYCLES = flash_power_pkg::RESET_HOLD_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic cs_n_i,
   input wire logic shared_io_reset_n_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_opcode_i,
   input wire logic [7:0] status_one_volatile_i,
   input wire logic [7:0] config_one_volatile_i,
   output logic active_power_o,
   output logic standby_o,
   output logic deep_sleep_o,
   output logic por_busy_o,
   output logic cmd_decode_en_o,
   output logic abort_o,
   output logic outputs_hiz_o,
   output logic cmd_ignored_o
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      flash_power_pkg::pwr_state_t st;
      logic [flash_power_pkg::CNT_W-1:0] cnt;
      logic [flash_power_pkg::CNT_W-1:0] cs_high_cnt;
      logic [flash_power_pkg::CNT_W-1:0] rst_low_cnt;
      logic [1:0] cs_sync;
      logic [1:0] rst_sync;
      logic active;
      logic ignored;
   } ctrl_state_t;

   localparam logic [flash_power_pkg::CNT_W-1:0] PU_LAST =
      flash_power_pkg::CNT_W'(POWER_UP_CYCLES - 1);
   localparam logic [flash_power_pkg::CNT_W-1:0] HOLD_LAST =
      flash_power_pkg::CNT_W'(RESET_HOLD_CYCLES - 1);
   localparam logic [flash_power_pkg::CNT_W-1:0] REL_LAST =
      flash_power_pkg::CNT_W'(flash_power_pkg::RELEASE_DELAY_CYC - 1);
   localparam logic [flash_power_pkg::CNT_W-1:0] DESEL_CNT =
      flash_power_pkg::CNT_W'(flash_power_pkg::DESELECT_CYC);
   localparam logic [flash_power_pkg::CNT_W-1:0] PULSE_CNT =
      flash_power_pkg::CNT_W'(flash_power_pkg::RESET_PULSE_CYC);
   localparam logic [flash_power_pkg::CNT_W-1:0] CNT_ONE =
      flash_power_pkg::CNT_W'(1);

   ctrl_state_t s_q;
   ctrl_state_t s_d;

   logic cs_n_s;
   logic rst_n_s;
   logic pending;
   logic quad_en;
   logic rst_qual;
   logic rst_fire;

   assign cs_n_s = s_q.cs_sync[1];
   assign rst_n_s = s_q.rst_sync[1];
   assign pending = status_one_volatile_i[flash_power_pkg::STATUS_PENDING_BIT];
   assign quad_en = config_one_volatile_i[flash_power_pkg::CONFIG_QUAD_BIT];

   // Pin acts as reset only after a long deselect or with quad off
   assign rst_qual = !quad_en
      || (cs_n_s && (s_q.cs_high_cnt > DESEL_CNT)); // see RULE_08
   assign rst_fire = rst_qual && (s_q.rst_low_cnt >= PULSE_CNT);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.cs_sync = {s_q.cs_sync[0], cs_n_i};
      s_d.rst_sync = {s_q.rst_sync[0], shared_io_reset_n_i};
      s_d.ignored = 1'b0;

      // Deselect timer, saturating
      if (!cs_n_s) begin
         s_d.cs_high_cnt = '0;
      end else if (s_q.cs_high_cnt <= DESEL_CNT) begin
         s_d.cs_high_cnt = s_q.cs_high_cnt + CNT_ONE;
      end

      // Low time of the qualified reset input, saturating
      if (rst_n_s || !rst_qual) begin
         s_d.rst_low_cnt = '0;
      end else if (s_q.rst_low_cnt < PULSE_CNT) begin
         s_d.rst_low_cnt = s_q.rst_low_cnt + CNT_ONE;
      end

      // Active while selected or while work is pending
      s_d.active = !cs_n_s || pending; // see RULE_01 see RULE_02

      case (s_q.st)
         flash_power_pkg::ST_POWER_ON: begin
            // Reset pin is only sampled when the power-up delay ends
            s_d.rst_low_cnt = '0; // see RULE_09
            if (s_q.cnt >= PU_LAST) begin // see RULE_06
               s_d.cnt = '0;
               s_d.st = rst_n_s ? flash_power_pkg::ST_RUN
                                : flash_power_pkg::ST_POR_HOLD;
            end else begin
               s_d.cnt = s_q.cnt + CNT_ONE;
            end
         end
         flash_power_pkg::ST_POR_HOLD: begin
            // Reset still low past power-up: stay in reset
            s_d.rst_low_cnt = '0;
            if (rst_n_s) begin
               s_d.st = flash_power_pkg::ST_RUN; // see RULE_10
            end
         end
         flash_power_pkg::ST_RUN: begin
            if (rst_fire) begin
               s_d.st = flash_power_pkg::ST_HW_RESET;
               s_d.cnt = '0;
            end else if (cmd_valid_i
                  && cmd_opcode_i == flash_power_pkg::OP_DEEP_SLEEP) begin
               if (!pending) begin
                  s_d.st = flash_power_pkg::ST_DEEP_SLEEP; // see RULE_03
               end else begin
                  s_d.ignored = 1'b1; // see RULE_04
               end
            end
         end
         flash_power_pkg::ST_DEEP_SLEEP: begin
            if (rst_fire) begin
               s_d.st = flash_power_pkg::ST_HW_RESET;
               s_d.cnt = '0;
            end else if (cmd_valid_i) begin
               if (cmd_opcode_i == flash_power_pkg::OP_DEEP_SLEEP_RELEASE)
               begin
                  s_d.st = flash_power_pkg::ST_RELEASING; // see RULE_05
                  s_d.cnt = '0;
               end else begin
                  s_d.ignored = 1'b1; // see RULE_05
               end
            end
         end
         flash_power_pkg::ST_RELEASING: begin
            if (rst_fire) begin
               s_d.st = flash_power_pkg::ST_HW_RESET;
               s_d.cnt = '0;
            end else begin
               if (cmd_valid_i) begin
                  s_d.ignored = 1'b1;
               end
               if (s_q.cnt >= REL_LAST) begin
                  s_d.st = flash_power_pkg::ST_RUN; // see RULE_13
                  s_d.cnt = '0;
               end else begin
                  s_d.cnt = s_q.cnt + CNT_ONE;
               end
            end
         end
         flash_power_pkg::ST_HW_RESET: begin
            // Abort, float outputs and drop commands for the hold time
            if (cmd_valid_i) begin
               s_d.ignored = 1'b1; // see RULE_12
            end
            s_d.rst_low_cnt = '0;
            if (s_q.cnt >= HOLD_LAST) begin
               s_d.st = flash_power_pkg::ST_RUN;
               s_d.cnt = '0;
            end else begin
               s_d.cnt = s_q.cnt + CNT_ONE;
            end
         end
         default: begin
            s_d.st = flash_power_pkg::ST_POWER_ON;
            s_d.cnt = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_q.st <= flash_power_pkg::ST_POWER_ON;
         s_q.cnt <= '0;
         s_q.cs_high_cnt <= '0;
         s_q.rst_low_cnt <= '0;
         s_q.cs_sync <= 2'h3;
         s_q.rst_sync <= 2'h3;
         s_q.active <= 1'b0;
         s_q.ignored <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic in_run;

   assign in_run = (s_q.st == flash_power_pkg::ST_RUN);
   assign active_power_o = in_run && s_q.active; // see RULE_01
   assign standby_o = in_run && !s_q.active; // see RULE_02
   assign deep_sleep_o = (s_q.st == flash_power_pkg::ST_DEEP_SLEEP)
      || (s_q.st == flash_power_pkg::ST_RELEASING);
   assign por_busy_o = (s_q.st == flash_power_pkg::ST_POWER_ON)
      || (s_q.st == flash_power_pkg::ST_POR_HOLD);
   assign cmd_decode_en_o = in_run; // see RULE_13
   assign abort_o = (s_q.st == flash_power_pkg::ST_HW_RESET); // see RULE_12
   assign outputs_hiz_o = !in_run; // see RULE_12
   assign cmd_ignored_o = s_q.ignored;

endmodule

`default_nettype wire

// ===== testbench/flash_power_chk.sv
// Assertion checker for the flash power and reset controller
`timescale 1ns/10ps
`default_nettype none
module flash_power_chk #(
   parameter int POWER_UP_CYCLES = 20,
   parameter int RESET_HOLD_CYCLES = 30
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic cs_n_i,
   input wire logic shared_io_reset_n_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_opcode_i,
   input wire logic [7:0] status_one_volatile_i,
   input wire logic [7:0] config_one_volatile_i,
   input wire logic active_power_o,
   input wire logic deep_sleep_o,
   input wire logic por_busy_o,
   input wire logic cmd_decode_en_o,
   input wire logic abort_o,
   input wire logic cmd_ignored_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic [7:0] low_q;
   int hold_q;
   int wake_q;
   localparam int WAKE_LEN = flash_power_pkg::RELEASE_DELAY_CYC + 1;
   // Low time of the pin with quad off outside power-on reset, and length of the abort
   always_ff @(posedge clk_i) begin
      low_q <= (srst_i | shared_io_reset_n_i | por_busy_o |
         config_one_volatile_i[1]) ? 8'h00 : low_q + 8'h01;
      hold_q <= (abort_o && !srst_i) ? hold_q + 1 : 0;
      // Cycles since an accepted release, while still asleep
      if (srst_i || !deep_sleep_o) begin
         wake_q <= 0;
      end else if (wake_q != 0) begin
         wake_q <= wake_q + 1;
      end else if (cmd_valid_i && cmd_opcode_i == 8'hab && !abort_o) begin
         wake_q <= 1;
      end
   end
   sequence take_sleep;
      cmd_valid_i && cmd_opcode_i == 8'hb9 && cmd_decode_en_o;
   endsequence
   sequence take_wake;
      deep_sleep_o && cmd_valid_i && cmd_opcode_i == 8'hab
      ##1 deep_sleep_o && !cmd_ignored_o && !abort_o;
   endsequence
   a_sleep_entry: assert property (
      take_sleep ##0 !status_one_volatile_i[0] |=> deep_sleep_o)
      else $error("deep sleep not entered");
   a_sleep_refused: assert property (
      take_sleep ##0 status_one_volatile_i[0] |=>
      !deep_sleep_o && cmd_ignored_o) else $error("busy sleep taken");
   a_sleep_ignores: assert property (
      deep_sleep_o && cmd_valid_i && cmd_opcode_i != 8'hab |=>
      cmd_ignored_o) else $error("sleep command not ignored");
   a_wake_start: assert property (
      take_wake |-> wake_q == 1 && !cmd_decode_en_o)
      else $error("release not started");
   a_wake_delay: assert property (
      $fell(deep_sleep_o) && !abort_o |->
      wake_q == WAKE_LEN && cmd_decode_en_o)
      else $error("release delay wrong");
   a_select_active: assert property (
      !cs_n_i [*3] ##1 cmd_decode_en_o |-> active_power_o)
      else $error("selected but not active");
   a_pending_active: assert property (
      status_one_volatile_i[0] ##1 cmd_decode_en_o |-> active_power_o)
      else $error("pending but not active");
   a_por_hold: assert property (
      (por_busy_o && !shared_io_reset_n_i) [*3] |=> por_busy_o)
      else $error("left power-on reset with pin low");
   a_reset_fire: assert property (low_q == 8'h1e |-> abort_o)
      else $error("reset pulse not taken");
   a_hold_len: assert property (
      $fell(abort_o) |-> hold_q == RESET_HOLD_CYCLES)
      else $error("reset hold length wrong");
   a_abort_ignore: assert property (
      abort_o && cmd_valid_i |=> cmd_ignored_o)
      else $error("command taken in reset");
endmodule
bind flash_power_mode_reset_ctrl flash_power_chk #(
   .POWER_UP_CYCLES(POWER_UP_CYCLES),
   .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) chk (
   .clk_i(clk_i),
   .srst_i(srst_i),
   .cs_n_i(cs_n_i),
   .shared_io_reset_n_i(shared_io_reset_n_i),
   .cmd_valid_i(cmd_valid_i),
   .cmd_opcode_i(cmd_opcode_i),
   .status_one_volatile_i(status_one_volatile_i),
   .config_one_volatile_i(config_one_volatile_i),
   .active_power_o(active_power_o),
   .deep_sleep_o(deep_sleep_o),
   .por_busy_o(por_busy_o),
   .cmd_decode_en_o(cmd_decode_en_o),
   .abort_o(abort_o),
   .cmd_ignored_o(cmd_ignored_o));
`default_nettype wire

// ===== testbench/flash_power_mode_reset_ctrl_bench.sv
// Self-checking bench for the flash power and reset controller
`timescale 1ns/10ps
`default_nettype none
module flash_power_mode_reset_ctrl_bench;
   logic clk_i = 1'b0, srst_i = 1'b1, shared_io_reset_n_i = 1'b0;
   logic go = 1'b0, sel = 1'b0, cs_n_i, cmd_valid_i;
   logic [7:0] status_one_volatile_i = 8'h00;
   logic [7:0] config_one_volatile_i = 8'h00;
   logic [7:0] op = 8'h00, r, cmd_opcode_i;
   logic active_power_o, standby_o, deep_sleep_o, por_busy_o;
   logic cmd_decode_en_o, abort_o, outputs_hiz_o, cmd_ignored_o;
   int bad_count = 0, tests_run = 0, k;
   integer seed = 32'he9416d8d;
   initial forever #4 clk_i = ~clk_i;
   spi_host_model host (.clk_i(clk_i), .go_i(go), .op_i(op), .sel_i(sel),
      .cs_n_o(cs_n_i), .cmd_valid_o(cmd_valid_i), .cmd_opcode_o(cmd_opcode_i));
   flash_power_mode_reset_ctrl #(.POWER_UP_CYCLES(20),
      .RESET_HOLD_CYCLES(30)) uut (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .cs_n_i(cs_n_i),
      .shared_io_reset_n_i(shared_io_reset_n_i),
      .cmd_valid_i(cmd_valid_i),
      .cmd_opcode_i(cmd_opcode_i),
      .status_one_volatile_i(status_one_volatile_i),
      .config_one_volatile_i(config_one_volatile_i),
      .active_power_o(active_power_o),
      .standby_o(standby_o),
      .deep_sleep_o(deep_sleep_o),
      .por_busy_o(por_busy_o),
      .cmd_decode_en_o(cmd_decode_en_o),
      .abort_o(abort_o),
      .outputs_hiz_o(outputs_hiz_o),
      .cmd_ignored_o(cmd_ignored_o));
   task automatic end_of_test;
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: %h, expected %h", $time, g, e);
      end
   endtask
   // Expected drop flag for a command sent while asleep
   function automatic logic [7:0] sleep_reply(input logic [7:0] o);
      return {7'h00, o != 8'hab};
   endfunction
   task automatic cmd(input logic [7:0] o, input logic [7:0] ign);
      @(posedge clk_i) go <= 1'b1;
      op <= o;
      @(posedge clk_i) go <= 1'b0;
      @(posedge clk_i);
      #1 chk(cmd_ignored_o, ign);
   endtask
   task automatic wait_den(input int lim);
      for (int i = 0; i < lim && cmd_decode_en_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      if (cmd_decode_en_o !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
   endtask
   initial begin
      // ----------------------------------------
      // Power-up with the pin low at first
      // ----------------------------------------
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      shared_io_reset_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      #1 chk(por_busy_o, 8'h01);
      repeat (6) @(posedge clk_i);
      #1 chk(cmd_decode_en_o, 8'h01);
      @(posedge clk_i) sel <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1 chk(active_power_o, 8'h01);
      @(posedge clk_i) sel <= 1'b0;
      status_one_volatile_i <= 8'h01;
      repeat (6) @(posedge clk_i);
      #1 chk({active_power_o, standby_o}, 8'h02);
      cmd(8'hb9, 8'h01);
      #1 chk(deep_sleep_o, 8'h00);
      @(posedge clk_i) status_one_volatile_i <= 8'($random(seed)) & 8'hfe;
      repeat (3) @(posedge clk_i);
      #1 chk({active_power_o, standby_o}, 8'h01);
      for (k = 0; k < 2; k++) begin
         cmd(8'hb9, 8'h00);
         #1 chk(deep_sleep_o, 8'h01);
         repeat (6) begin
            r = 8'($random(seed));
            r = (r == 8'hab) ? 8'h9f : r;
            cmd(r, sleep_reply(r));
         end
         cmd(8'hab, sleep_reply(8'hab));
         wait_den(400);
         chk(deep_sleep_o, 8'h00);
      end
      // ----------------------------------------
      // Reset pin, quad off then quad on
      // ----------------------------------------
      @(posedge clk_i) shared_io_reset_n_i <= 1'b0;
      repeat (32) @(posedge clk_i);
      #1 chk({abort_o, outputs_hiz_o}, 8'h03);
      cmd(8'h05, 8'h01);
      @(posedge clk_i) shared_io_reset_n_i <= 1'b1;
      wait_den(60);
      @(posedge clk_i) config_one_volatile_i <= 8'h02;
      sel <= 1'b1;
      repeat (4) @(posedge clk_i);
      shared_io_reset_n_i <= 1'b0;
      repeat (36) @(posedge clk_i);
      #1 chk(abort_o, 8'h00);
      @(posedge clk_i) sel <= 1'b0;
      repeat (45) @(posedge clk_i);
      #1 chk(abort_o, 8'h01);
      @(posedge clk_i) shared_io_reset_n_i <= 1'b1;
      wait_den(60);
      // Second power-up with the pin held low past its end
      @(posedge clk_i) srst_i <= 1'b1;
      shared_io_reset_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      #1 chk(por_busy_o, 8'h01);
      @(posedge clk_i) shared_io_reset_n_i <= 1'b1;
      wait_den(20);
      repeat (2) @(posedge clk_i);
      cmd(8'hb9, 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== testbench/spi_host_model.sv
// Host side model: chip select and decoded command pulses
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [7:0] op_i,
   input wire logic sel_i,
   output logic cs_n_o,
   output logic cmd_valid_o,
   output logic [7:0] cmd_opcode_o
);
   initial cs_n_o = 1'b1;
   initial cmd_valid_o = 1'b0;
   initial cmd_opcode_o = 8'h00;
   // Deselected unless told; idle opcode lines toggle
   always @(posedge clk_i) begin
      cs_n_o <= !(go_i || sel_i);
      cmd_valid_o <= go_i;
      cmd_opcode_o <= go_i ? op_i : ~cmd_opcode_o;
   end
endmodule
`default_nettype wire
